// [design/tsar_readout_regs.svh]
`ifndef TSAR_READOUT_REGS_SVH
`define TSAR_READOUT_REGS_SVH

// Clock and timing figures
`define TSAR_CLK_PERIOD_NS   10
`define TSAR_TEMP_TIME_NS    100000
`define TSAR_TEMP_INT_NS     60000

// Frame layout
`define TSAR_FRAME_BITS      16
`define TSAR_SAR_BITS        12
`define TSAR_SAR_TOP         4'hB
`define TSAR_SAR_START       12'h800
`define TSAR_LAST_SAR_FALL   5'h0C
`define TSAR_LAST_FALL       5'h10
`define TSAR_ALL_ONES        16'hFFFF

// Channel identifiers and sequencer
`define TSAR_TEMP_CHAN       4'h8
`define TSAR_SEQ_RESTART     3'h7

// Moving average: the accumulator carries the average times eight
`define TSAR_AVG_SHIFT       3
`define TSAR_ACC_BITS        15

// Control word after power-on
`define TSAR_CTRL_RESET      12'h000

`endif

// [design/tsar_pkg.sv]
`default_nettype none
package tsar_pkg;
  // Control bits steering the converter
  typedef struct packed {
    logic [7:0] seq_mask;
    logic       temp_channel_select;
    logic       temp_avg_enable;
    logic       external_reference_select;
    logic       power_down_bit;
  } tsar_ctrl_s;

  // One result word as it leaves on the serial line
  typedef struct packed {
    logic [3:0]  chan;
    logic [11:0] data;
  } tsar_result_s;

  typedef enum logic [1:0] {T_IDLE, T_INTEG, T_CONV} tsar_temp_e;
endpackage : tsar_pkg
`default_nettype wire

// [design/tsar_readout.sv]
`include "tsar_readout_regs.svh"
`default_nettype none

// Small result buffer between the converter and the serial shifter
module tsar_fifo #(
  parameter int W = 16,
  parameter int D = 4
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic          push;
  logic          pop;
  assign in_ready  = (count != (AW+1)'(D));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  // Storage writes
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  // Pointers and fill level
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(D-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(D-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // tsar_fifo
module tsar_readout
  import tsar_pkg::*;
#(
  parameter int TEMP_CYCLES = `TSAR_TEMP_TIME_NS / `TSAR_CLK_PERIOD_NS,
  parameter int INT_CYCLES  = `TSAR_TEMP_INT_NS / `TSAR_CLK_PERIOD_NS,
  parameter int FIFO_DEPTH  = 4
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              cs_n_pin,
  input  wire logic              sclk_pin,
  output logic                   dout_o,
  output logic                   dout_oe,
  input  wire logic              ctrl_wr,
  input  wire tsar_ctrl_s        ctrl_in,
  output tsar_ctrl_s             ctrl,
  input  wire logic              cmp_in,
  input  wire logic signed [11:0] temp_raw,
  output logic            [11:0] dac_code,
  output logic            [3:0]  mux_sel,
  output logic                   track_hold,
  output logic                   ref_ext_sel,
  output logic                   temp_conv_busy,
  output logic                   partial_pd
);
  // Pin synchronisers; stage one feeds stage two only
  logic [1:0] cs_sync;
  logic [1:0] sclk_sync;
  logic [1:0] cmp_sync;
  logic       cs_d;
  logic       sclk_d;
  logic       cs_fall;
  logic       cs_rise;
  logic       sclk_fall;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_sync   <= 2'h3;
      sclk_sync <= 2'h0;
      cmp_sync  <= 2'h0;
      cs_d      <= 1'b1;
      sclk_d    <= 1'b0;
    end else begin
      cs_sync   <= {cs_sync[0], cs_n_pin};
      sclk_sync <= {sclk_sync[0], sclk_pin};
      cmp_sync  <= {cmp_sync[0], cmp_in};
      cs_d      <= cs_sync[1];
      sclk_d    <= sclk_sync[1];
    end
  end
  assign cs_fall   = cs_d & ~cs_sync[1];
  assign cs_rise   = ~cs_d & cs_sync[1];
  assign sclk_fall = sclk_d & ~sclk_sync[1] & ~cs_sync[1];
  // Control word; every bit zero after reset, so internal reference and normal mode
  logic avg_bit_change;
  assign avg_bit_change = ctrl_wr & (ctrl_in.temp_avg_enable != ctrl.temp_avg_enable);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= tsar_ctrl_s'(`TSAR_CTRL_RESET);
    end else if (ctrl_wr) begin
      ctrl <= ctrl_in;
    end
  end
  assign ref_ext_sel = ctrl.external_reference_select;
  // Power state follows the bit only between frames, so a frame is never cut short
  logic pd_enter;
  assign pd_enter = cs_rise & ctrl.power_down_bit & ~partial_pd;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      partial_pd <= 1'b0;
    end else if (cs_rise) begin
      partial_pd <= ctrl.power_down_bit;
    end
  end
  // Channel sequencer: next enabled channel after the current one
  logic [2:0] cur_chan;
  logic [2:0] next_chan;
  always_comb begin
    next_chan = cur_chan;
    for (int k = 1; k <= 8; k++) begin
      if (ctrl.seq_mask[3'(cur_chan + 3'(k))] && next_chan == cur_chan) begin
        next_chan = 3'(cur_chan + 3'(k));
      end
    end
    if (ctrl.seq_mask == '0) begin
      next_chan = '0;
    end
  end

  // Frame control
  logic       frame_on;
  logic [4:0] fall_cnt;
  logic       frame_adc;
  logic       frame_temp;
  logic       frame_ok;
  logic       res_ready;
  logic       temp_done;
  logic       push;
  logic       pop;
  logic       head_valid;
  tsar_result_s head;
  tsar_result_s push_word;
  tsar_temp_e tphase;
  // A frame converts only when powered, not blocked by a temperature run and room remains
  assign frame_ok = cs_fall & ~partial_pd & (tphase == T_IDLE) & res_ready;
  assign pop      = cs_fall & ~partial_pd & ~temp_conv_busy & head_valid;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_on   <= 1'b0;
      fall_cnt   <= '0;
      frame_adc  <= 1'b0;
      frame_temp <= 1'b0;
      cur_chan   <= `TSAR_SEQ_RESTART;
      mux_sel    <= '0;
      track_hold <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        cur_chan <= `TSAR_SEQ_RESTART;
      end
      if (cs_fall) begin
        frame_on   <= 1'b1;
        fall_cnt   <= '0;
        frame_adc  <= frame_ok & ~ctrl.temp_channel_select;
        frame_temp <= frame_ok & ctrl.temp_channel_select;
        track_hold <= frame_ok & ~ctrl.temp_channel_select;
        if (frame_ok && !ctrl.temp_channel_select) begin
          cur_chan <= next_chan;
          mux_sel  <= {1'b0, next_chan};
        end else if (frame_ok) begin
          mux_sel <= `TSAR_TEMP_CHAN;
        end
      end else if (cs_rise) begin
        frame_on   <= 1'b0; // Early rise aborts the conversion
        frame_adc  <= 1'b0;
        track_hold <= 1'b0;
      end else if (sclk_fall && frame_on && fall_cnt != `TSAR_LAST_FALL) begin
        fall_cnt <= fall_cnt + 5'h01;
        if (fall_cnt == `TSAR_LAST_SAR_FALL) begin
          track_hold <= 1'b0;
        end
      end
    end
  end

  // Successive approximation, one decision per serial clock fall
  logic [3:0] sar_bit;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dac_code <= '0;
      sar_bit  <= '0;
    end else if (frame_ok && !ctrl.temp_channel_select) begin
      dac_code <= `TSAR_SAR_START;
      sar_bit  <= `TSAR_SAR_TOP;
    end else if (sclk_fall && frame_adc && fall_cnt < `TSAR_LAST_SAR_FALL) begin
      // Keep the trial bit while the input is at or above it: code = floor(Vin/LSB)
      dac_code[sar_bit] <= cmp_sync[1];
      if (sar_bit != '0) begin
        dac_code[sar_bit - 4'h1] <= 1'b1;
        sar_bit <= sar_bit - 4'h1;
      end
    end
  end

  // Temperature run: integration, then conversion without host help
  logic [$clog2(TEMP_CYCLES+1)-1:0] tcnt;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tphase <= T_IDLE;
      tcnt   <= '0;
    end else begin
      unique case (tphase)
        T_IDLE: begin
          if (frame_ok && ctrl.temp_channel_select) begin
            tphase <= T_INTEG;
            tcnt   <= '0;
          end
        end
        T_INTEG: begin
          tcnt <= tcnt + 1'b1;
          if (tcnt == $bits(tcnt)'(INT_CYCLES - 1)) begin
            tphase <= T_CONV;
          end
        end
        T_CONV: begin
          tcnt <= tcnt + 1'b1;
          if (tcnt == $bits(tcnt)'(TEMP_CYCLES - 1)) begin
            tphase <= T_IDLE;
          end
        end
      endcase
    end
  end
  assign temp_conv_busy = (tphase != T_IDLE);
  assign temp_done = (tphase == T_CONV) && (tcnt == $bits(tcnt)'(TEMP_CYCLES - 1));
  // Moving average held as eight times the value to keep the fraction bits
  logic signed [`TSAR_ACC_BITS-1:0] avg_acc;
  logic signed [`TSAR_ACC_BITS-1:0] raw_ext;
  logic                             avg_seeded;
  logic                             avg_active;
  logic                             avg_clear;
  logic signed [11:0]               temp_word;
  assign avg_active = ctrl.temp_avg_enable & ctrl.temp_channel_select;
  assign avg_clear  = avg_bit_change | (pd_enter & ctrl.temp_avg_enable);
  assign raw_ext    = `TSAR_ACC_BITS'(temp_raw);
  // A sample landing with a clear seeds the fresh average, so it is not lost
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      avg_acc    <= '0;
      avg_seeded <= 1'b0;
    end else if (temp_done && avg_active) begin
      avg_seeded <= 1'b1;
      if (!avg_seeded || avg_clear) begin
        avg_acc <= raw_ext <<< `TSAR_AVG_SHIFT;
      end else begin
        avg_acc <= avg_acc - (avg_acc >>> `TSAR_AVG_SHIFT) + raw_ext;
      end
    end else if (avg_clear) begin
      avg_seeded <= 1'b0;
    end
  end
  // Reported temperature word, average truncated back to 12 bits
  always_comb begin
    if (avg_active && avg_seeded) begin
      temp_word = 12'(((avg_acc - (avg_acc >>> `TSAR_AVG_SHIFT) + raw_ext)
                       >>> `TSAR_AVG_SHIFT));
    end else begin
      temp_word = temp_raw;
    end
  end
  // Results enter the buffer when done and leave at the next frame start that is powered and outside a temperature run
  logic adc_done;
  assign adc_done = sclk_fall & frame_adc & (fall_cnt == `TSAR_LAST_FALL - 5'h01);
  assign push     = adc_done | temp_done;
  always_comb begin
    push_word.chan = {1'b0, cur_chan};
    push_word.data = dac_code;
    if (temp_done) begin
      push_word.chan = `TSAR_TEMP_CHAN;
      push_word.data = temp_word;
    end
  end
  tsar_fifo #(
    .W ($bits(tsar_result_s)),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (push),
    .in_ready  (res_ready),
    .in_data   (push_word),
    .out_valid (head_valid),
    .out_ready (pop),
    .out_data  (head)
  );
  // Serial shifter; frames that pop no result (buffer empty, powered down or temperature busy) send all ones
  logic [`TSAR_FRAME_BITS-1:0] shreg;
  assign dout_o = shreg[`TSAR_FRAME_BITS-1];
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shreg   <= `TSAR_ALL_ONES;
      dout_oe <= 1'b0;
    end else if (cs_fall) begin
      dout_oe <= 1'b1;
      shreg   <= pop ? head : `TSAR_ALL_ONES;
    end else if (cs_rise || (sclk_fall && fall_cnt == `TSAR_LAST_FALL - 5'h01)) begin
      dout_oe <= 1'b0;
      shreg   <= {shreg[`TSAR_FRAME_BITS-2:0], 1'b1};
    end else if (sclk_fall && frame_on) begin
      shreg <= {shreg[`TSAR_FRAME_BITS-2:0], 1'b1};
    end
  end
  // Checks
  logic [$clog2(TEMP_CYCLES+1):0] busy_len;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_len <= '0;
    end else begin
      busy_len <= temp_conv_busy ? busy_len + 1'b1 : '0;
    end
  end
  AST_BUSY_RISE: assert property (@(posedge clk) disable iff (!rst_b)
    (frame_ok && ctrl.temp_channel_select) |=> temp_conv_busy && tphase == T_INTEG)
    else $error("busy did not rise with temperature start");
  AST_BUSY_LEN: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(temp_conv_busy) |-> $past(busy_len) == $bits(busy_len)'(TEMP_CYCLES - 1))
    else $error("temperature run length wrong");
  AST_AUTO_CONV: assert property (@(posedge clk) disable iff (!rst_b)
    (tphase == T_INTEG && tcnt == $bits(tcnt)'(INT_CYCLES - 1)) |=> tphase == T_CONV)
    else $error("conversion phase did not follow integration");
  AST_AVG_RESTART: assert property (@(posedge clk) disable iff (!rst_b)
    (avg_bit_change && !temp_done) |=> !avg_seeded)
    else $error("average not restarted on enable change");
  AST_AVG_KEEP: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl_wr && !avg_bit_change && avg_seeded && !pd_enter) |=> avg_seeded)
    else $error("average lost on unrelated write");
  AST_AVG_SEED: assert property (@(posedge clk) disable iff (!rst_b)
    (temp_done && avg_active && !avg_seeded) |-> temp_word == temp_raw)
    else $error("first averaged result is not the raw sample");
  AST_REF_SEL: assert property (@(posedge clk) disable iff (!rst_b)
    ctrl_wr |=> ref_ext_sel == $past(ctrl_in.external_reference_select))
    else $error("reference select did not follow the write");
  AST_RESULT_NEXT: assert property (@(posedge clk) disable iff (!rst_b)
    (adc_done && res_ready) |=> head_valid)
    else $error("finished result not queued for next frame");
  AST_SEQ_MASK: assert property (@(posedge clk) disable iff (!rst_b)
    (frame_ok && !ctrl.temp_channel_select && ctrl.seq_mask != '0)
      |=> $past(ctrl.seq_mask[next_chan]) && mux_sel == {1'b0, $past(next_chan)})
    else $error("sequencer picked a channel outside the mask");
  AST_PD_ONES: assert property (@(posedge clk) disable iff (!rst_b)
    (cs_fall && partial_pd) |=> shreg == `TSAR_ALL_ONES && !frame_adc && !frame_temp)
    else $error("powered-down frame did not send ones");
  COV_ADC_FRAME: cover property (@(posedge clk) disable iff (!rst_b) adc_done);
  COV_TEMP_DONE: cover property (@(posedge clk) disable iff (!rst_b) temp_done && avg_active);
  COV_AVG_ACCUM: cover property (@(posedge clk) disable iff (!rst_b)
    temp_done && avg_active && avg_seeded);
  COV_PD_ENTER: cover property (@(posedge clk) disable iff (!rst_b) pd_enter);
endmodule // tsar_readout
`default_nettype wire

// [bench/tsar_host_model.sv]
`default_nettype none
// Host serial controller: frames transfers, reads the result word
module tsar_host_model #(
  parameter int HALF_NS = 80
) (
  input  wire logic dout_o,
  input  wire logic dout_oe,
  output var  logic cs_n_pin,
  output var  logic sclk_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  logic      last = 1'b0;
  wire logic line;

  // A released line shows the inverse of its last value, never a lucky match
  assign line = dout_oe ? dout_o : ~last;
  always @(dout_o or dout_oe) begin
    if (dout_oe) last = dout_o;
  end

  // Idle: select high, serial clock parked high
  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b1;
  end

  // One 16-clock frame; the clock only runs inside it, as it also drives the SAR
  task automatic frame(output logic [15:0] word);
    cs_n_pin = 1'b0;
    #(HALF_NS);
    for (int i = 15; i >= 0; i--) begin
      word[i] = line; // Taken just before the fall that shifts it out
      sclk_pin = 1'b0;
      #(HALF_NS);
      sclk_pin = 1'b1;
      #(HALF_NS);
    end
    cs_n_pin = 1'b1;
    #(4 * HALF_NS);
  endtask

  // Frame cut after two clocks; select rises early so the block must drop the conversion
  task automatic abort();
    cs_n_pin = 1'b0;
    #(HALF_NS);
    repeat (2) begin
      sclk_pin = 1'b0;
      #(HALF_NS);
      sclk_pin = 1'b1;
      #(HALF_NS);
    end
    cs_n_pin = 1'b1;
    #(4 * HALF_NS);
  endtask

  // Code to quarter degrees; negative codes counted down from 4096
  function automatic int quarter_deg(input logic [11:0] code);
    return code[11] ? -(4096 - int'(code)) : int'(code);
  endfunction
endmodule // tsar_host_model
`default_nettype wire

// [bench/tsar_readout_test.sv]
`default_nettype none
module tsar_readout_test
  import tsar_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int TEMP_CYC = 200;
  localparam int VREF_INT = 2500;
  localparam int VREF_EXT = 2048;
  localparam int REF_WAIT = 50; // Short stand-in for the reference settling time

  logic               clk, rst_b, cs_n_pin, sclk_pin, dout_o, dout_oe, ctrl_wr, cmp_in;
  logic               track_hold, ref_ext_sel, temp_conv_busy, partial_pd;
  tsar_ctrl_s         ctrl_in, ctrl;
  logic signed [11:0] temp_raw;
  logic        [11:0] dac_code;
  logic        [3:0]  mux_sel;
  int                 vin_mv [8] = '{100, 300, 700, 900, 1200, 1500, 1800, 2000};
  int                 fails = 0, n_checks = 0, run = 0, busy_len = 0;

  tsar_readout #(.TEMP_CYCLES(TEMP_CYC), .INT_CYCLES(120), .FIFO_DEPTH(4)) tsar_readout_i (
    .clk(clk), .rst_b(rst_b), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .dout_o(dout_o),
    .dout_oe(dout_oe), .ctrl_wr(ctrl_wr), .ctrl_in(ctrl_in), .ctrl(ctrl), .cmp_in(cmp_in),
    .temp_raw(temp_raw), .dac_code(dac_code), .mux_sel(mux_sel), .track_hold(track_hold),
    .ref_ext_sel(ref_ext_sel), .temp_conv_busy(temp_conv_busy), .partial_pd(partial_pd));

  tsar_host_model tsar_host_model_i (
    .dout_o(dout_o), .dout_oe(dout_oe), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Ideal comparator against the trial level on the chosen reference
  always @(negedge clk) begin
    cmp_in <= vin_mv[mux_sel[2:0]] * 4096 >= int'(dac_code) * (ref_ext_sel ? VREF_EXT : VREF_INT);
  end

  // Length in clocks of the latest busy stretch
  always @(posedge clk) begin
    if (temp_conv_busy === 1'b1) begin
      run <= run + 1;
    end else if (run != 0) begin
      busy_len <= run;
      run <= 0;
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Control write: one-cycle strobe, word checked once it has landed
  task automatic wr_ctrl(input tsar_ctrl_s c);
    @(negedge clk);
    ctrl_in = c;
    ctrl_wr = 1'b1;
    @(negedge clk);
    ctrl_wr = 1'b0;
    @(negedge clk);
    check("ctrl", 16'(ctrl), 16'(c));
  endtask

  // One frame, then a bounded wait until no temperature run is pending
  task automatic xfer(output tsar_result_s r);
    @(negedge clk);
    tsar_host_model_i.frame(r);
    for (int i = 0; i < 1000 && temp_conv_busy !== 1'b0; i++) @(negedge clk);
    if (temp_conv_busy !== 1'b0) begin
      fails++;
      end_sim();
    end
  endtask

  task automatic t_reset();
    check("ctrl", 16'(ctrl), 16'h0000);
    check("ref", 16'(ref_ext_sel), 16'h0000);
    check("pd", 16'(partial_pd), 16'h0000);
    check("busy", 16'(temp_conv_busy), 16'h0000);
    check("oe", 16'(dout_oe), 16'h0000);
    $display("test reset done");
  endtask

  // Channels 1, 3, 6 cycled; each read one frame after its start
  task automatic t_seq(input logic ext);
    int           ch [4] = '{1, 3, 6, 1};
    int           vref;
    tsar_result_s r;
    vref = ext ? VREF_EXT : VREF_INT;
    wr_ctrl({8'h4A, 1'b0, 1'b0, ext, 1'b0});
    check("ref", 16'(ref_ext_sel), 16'(ext));
    repeat (REF_WAIT) @(negedge clk);
    xfer(r);
    for (int i = 0; i < 4; i++) begin
      xfer(r);
      check("word", r, {4'(ch[i]), 12'(vin_mv[ch[i]] * 4096 / vref)});
    end
    $display("test sequence done");
  endtask

  task automatic t_temp();
    tsar_result_s r;
    temp_raw = 12'sh064;
    wr_ctrl({8'h01, 1'b1, 1'b0, 1'b0, 1'b0});
    xfer(r);
    check("busy_len", 16'(busy_len), 16'(TEMP_CYC));
    temp_raw = 12'shF60;
    xfer(r);
    check("temp", r, 16'h8064);
    xfer(r);
    check("temp_neg", r, 16'h8F60);
    check("deg", 16'(tsar_host_model_i.quarter_deg(12'hF60) / 4), 16'hFFD8);
    $display("test temperature done");
  endtask

  // Per step: control write (zero = none), raw sample, expected word (zero = unchecked)
  task automatic t_avg();
    logic [11:0] wr [13] = '{12'h01C, 0, 0, 12'h03C, 12'h018, 12'h01C, 0, 0, 12'h01D, 0,
                             12'h01C, 0, 0};
    logic [11:0] raw [13] = '{12'h064, 12'h06C, 12'h06D, 12'h06E, 12'hF60, 12'hF68, 12'hF70,
                              12'hF71, 12'hF78, 0, 0, 12'h0C8, 12'h0D0};
    logic [15:0] exp [13] = '{0, 16'h8064, 16'h8065, 16'h8066, 16'h8067, 16'h8F60, 16'h8F68,
                              16'h8F69, 16'h8F6A, 16'hFFFF, 16'hFFFF, 0, 16'h80C8};
    tsar_result_s r;
    for (int i = 0; i < 13; i++) begin
      if (wr[i] != 0) wr_ctrl(wr[i]);
      temp_raw = raw[i];
      xfer(r);
      if (exp[i] != 0) check("avg", r, exp[i]);
      if (i == 8) check("pd_on", 16'(partial_pd), 16'h0001);
      if (i == 10) check("pd_off", 16'(partial_pd), 16'h0000);
    end
    $display("test averaging done");
  endtask

  // Result buffer through the block: a result waits, an aborted frame queues nothing
  task automatic t_fifo();
    tsar_result_s r;
    logic [15:0]  ch2;
    ch2 = {4'h2, 12'(vin_mv[2] * 4096 / VREF_INT)};
    wr_ctrl({8'h04, 1'b0, 1'b0, 1'b0, 1'b0});
    repeat (100) @(negedge clk);
    xfer(r);
    check("held", r, 16'h80C9);
    xfer(r);
    check("ch2", r, ch2);
    @(negedge clk);
    tsar_host_model_i.abort();
    check("abort_oe", 16'(dout_oe), 16'h0000);
    check("abort_th", 16'(track_hold), 16'h0000);
    xfer(r);
    check("empty", r, 16'hFFFF);
    xfer(r);
    check("ch2_again", r, ch2);
    check("mux", 16'(mux_sel), 16'h0002);
    $display("test buffer done");
  endtask

  // Main sequence
  initial begin
    rst_b = 1'b0;
    ctrl_wr = 1'b0;
    ctrl_in = '0;
    cmp_in = 1'b0;
    temp_raw = '0;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_seq(1'b0);
    t_seq(1'b1);
    t_temp();
    t_avg();
    t_fifo();
    end_sim();
  end
endmodule // tsar_readout_test
`default_nettype wire
